// ### hw/cfg_guard_defines.vh
/*
  Register offsets, field layouts and reset values of the mode-gated
  configuration write guard. Definitions only; included by bare name.
*/
`ifndef CFG_GUARD_DEFINES_VH
`define CFG_GUARD_DEFINES_VH

// Byte offsets of the register words (haddr[7:0])
`define CG_MODE_OFS      8'h00
`define CG_OE_OFS        8'h04
`define CG_SS_OFS        8'h08
`define CG_INSEL_OFS     8'h0C
`define CG_STATUS_OFS    8'h10
`define CG_CFG0_OFS      8'h20
`define CG_CFG1_OFS      8'h24
`define CG_CFG2_OFS      8'h28

// Field widths and positions
`define CG_NUM_OUT       12
`define CG_OE_W          12
`define CG_INSEL_W       2
`define CG_DIV_W         8
`define CG_MODE_READY_BIT 0
`define CG_STAT_ACTIVE_BIT 0
`define CG_STAT_READY_BIT  1

// Reset values
`define CG_MODE_RST      1'b0
`define CG_OE_RST        12'h000
`define CG_SS_RST        1'b0
`define CG_INSEL_RST     2'h0
`define CG_CFG_RST       32'h0000_0000

// Bus constants
`define CG_TRANS_NONSEQ  2'h2
`define CG_RESP_OKAY     1'b0

`endif

// ### hw/clk_div_out.v
/*
  One clock output channel: a divider that toggles its output every
  divRatio+1 enabled cycles while run is high, and parks low otherwise.
  Assumes sys_clk, synchronous inputs and a divRatio that is stable.
*/
`timescale 1ns/1ps
`include "cfg_guard_defines.vh"

module clk_div_out
(
  // Clock and reset
  input  wire                   sys_clk,
  input  wire                   sys_rst,
  input  wire                   clkEn,
  // Control
  input  wire                   run,
  input  wire [`CG_DIV_W-1:0]   divRatio,
  // Clock out
  output wire                   clkOut
);

  reg [`CG_DIV_W-1:0] cnt_ff;
  reg                 clkOut_ff;

  // Divider; parked low whenever run drops
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff    <= 8'h00;
      clkOut_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!run)
      begin
        cnt_ff    <= 8'h00;
        clkOut_ff <= 1'b0;
      end
      else if (cnt_ff >= divRatio)
      begin
        cnt_ff    <= 8'h00;
        clkOut_ff <= ~clkOut_ff;
      end
      else
      begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign clkOut = clkOut_ff;

endmodule

// ### hw/mode_gated_config_write_guard.v
/*
  Configuration register bank of a multi-output clock generator with
  mode-gated write protection, reached over AHB-Lite, plus the twelve
  output dividers it steers.
  Assumes one synchronous clock, AHB-Lite single word transfers, and a
  host that sequences Ready/Active around protected writes.
*/
`timescale 1ns/1ps
`include "cfg_guard_defines.vh"

module mode_gated_config_write_guard
(
  // Clock, reset, enable
  input  wire                  sys_clk,
  input  wire                  sys_rst,
  input  wire                  clkEn,
  // AHB-Lite slave
  input  wire                  hsel,
  input  wire [31:0]           haddr,
  input  wire [1:0]            htrans,
  input  wire                  hwrite,
  input  wire [2:0]            hsize,
  input  wire                  hready,
  input  wire [31:0]           hwdata,
  output wire [31:0]           hrdata,
  output wire                  hreadyout,
  output wire                  hresp,
  // Clock outputs
  output wire [`CG_NUM_OUT-1:0] clkOut,
  // Live controls and state
  output wire                  ssEnable,
  output wire [`CG_INSEL_W-1:0] inputSel,
  output wire                  activeMode
);

  // Bus data phase bookkeeping
  reg                       wrPend_ff;
  reg  [7:0]                wrAddr_ff;
  reg  [31:0]               hrdata_ff;
  reg                       hreadyout_ff;
  reg                       hresp_ff;
  // Registers
  reg                       ready_ff;
  reg  [`CG_OE_W-1:0]       oe_ff;
  reg                       ss_ff;
  reg  [`CG_INSEL_W-1:0]    inSel_ff;
  reg  [31:0]               stage0_ff;
  reg  [31:0]               stage1_ff;
  reg  [31:0]               stage2_ff;
  reg  [31:0]               applied0_ff;
  reg  [31:0]               applied1_ff;
  reg  [31:0]               applied2_ff;
  reg                       active_ff;
  // Next values
  reg                       nxt_ready;
  reg  [`CG_OE_W-1:0]       nxt_oe;
  reg                       nxt_ss;
  reg  [`CG_INSEL_W-1:0]    nxt_inSel;
  reg  [31:0]               nxt_stage0;
  reg  [31:0]               nxt_stage1;
  reg  [31:0]               nxt_stage2;
  reg  [31:0]               nxt_rdata;
  wire                      addrPhase;
  wire                      wrPhase;
  wire [95:0]               appliedAll;

  // A transfer is taken when selected, NONSEQ and the bus is ready
  assign addrPhase = hsel & (htrans == `CG_TRANS_NONSEQ) & hready;
  assign wrPhase   = wrPend_ff;

  // Register writes; exempt registers in any mode, the rest in Ready only
  always @*
  begin
    nxt_ready  = ready_ff;
    nxt_oe     = oe_ff;
    nxt_ss     = ss_ff;
    nxt_inSel  = inSel_ff;
    nxt_stage0 = stage0_ff;
    nxt_stage1 = stage1_ff;
    nxt_stage2 = stage2_ff;
    if (wrPhase)
    begin
      case (wrAddr_ff)
        `CG_MODE_OFS:  nxt_ready = hwdata[`CG_MODE_READY_BIT];
        `CG_OE_OFS:    nxt_oe    = hwdata[`CG_OE_W-1:0];
        `CG_SS_OFS:    nxt_ss    = hwdata[0];
        `CG_INSEL_OFS: nxt_inSel = hwdata[`CG_INSEL_W-1:0];
        `CG_CFG0_OFS:
        begin
          if (ready_ff)
            nxt_stage0 = hwdata;
        end
        `CG_CFG1_OFS:
        begin
          if (ready_ff)
            nxt_stage1 = hwdata;
        end
        `CG_CFG2_OFS:
        begin
          if (ready_ff)
            nxt_stage2 = hwdata;
        end
        default:
        begin
          nxt_ready = ready_ff;
        end
      endcase
    end
  end

  // Read mux on next values so a write just before a read is seen
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[7:0])
      `CG_MODE_OFS:   nxt_rdata[`CG_MODE_READY_BIT] = nxt_ready;
      `CG_OE_OFS:     nxt_rdata[`CG_OE_W-1:0] = nxt_oe;
      `CG_SS_OFS:     nxt_rdata[0] = nxt_ss;
      `CG_INSEL_OFS:  nxt_rdata[`CG_INSEL_W-1:0] = nxt_inSel;
      `CG_STATUS_OFS:
      begin
        nxt_rdata[`CG_STAT_ACTIVE_BIT] = ~nxt_ready;
        nxt_rdata[`CG_STAT_READY_BIT]  = nxt_ready;
      end
      `CG_CFG0_OFS:   nxt_rdata = nxt_stage0;
      `CG_CFG1_OFS:   nxt_rdata = nxt_stage1;
      `CG_CFG2_OFS:   nxt_rdata = nxt_stage2;
      default:        nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPend_ff    <= 1'b0;
      wrAddr_ff    <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `CG_RESP_OKAY;
    end
    else if (clkEn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `CG_RESP_OKAY;
      wrPend_ff    <= addrPhase & hwrite;
      if (addrPhase)
      begin
        wrAddr_ff <= haddr[7:0];
      end
      if (addrPhase & ~hwrite)
      begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  // Register state and mode tracking
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ready_ff    <= `CG_MODE_RST;
      oe_ff       <= `CG_OE_RST;
      ss_ff       <= `CG_SS_RST;
      inSel_ff    <= `CG_INSEL_RST;
      stage0_ff   <= `CG_CFG_RST;
      stage1_ff   <= `CG_CFG_RST;
      stage2_ff   <= `CG_CFG_RST;
      active_ff   <= 1'b0;
    end
    else if (clkEn)
    begin
      ready_ff  <= nxt_ready;
      oe_ff     <= nxt_oe;
      ss_ff     <= nxt_ss;
      inSel_ff  <= nxt_inSel;
      stage0_ff <= nxt_stage0;
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
      active_ff <= ~nxt_ready;
    end
  end

  // Applied copy feeds the dividers; reloaded on each Ready to Active step
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      applied0_ff <= `CG_CFG_RST;
      applied1_ff <= `CG_CFG_RST;
      applied2_ff <= `CG_CFG_RST;
    end
    else if (clkEn)
    begin
      if (ready_ff & ~nxt_ready)
      begin
        applied0_ff <= stage0_ff;
        applied1_ff <= stage1_ff;
        applied2_ff <= stage2_ff;
      end
    end
  end

  assign appliedAll = {applied2_ff, applied1_ff, applied0_ff};

  // One divider per output, running only while Active and enabled
  genvar i;
  generate
    for (i = 0; i < `CG_NUM_OUT; i = i + 1)
    begin : gOut
      clk_div_out uDiv
      (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .run      (active_ff & oe_ff[i]),
        .divRatio (appliedAll[i*`CG_DIV_W +: `CG_DIV_W]),
        .clkOut   (clkOut[i])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  assign hrdata     = hrdata_ff;
  assign hreadyout  = hreadyout_ff;
  assign hresp      = hresp_ff;
  assign ssEnable   = ss_ff;
  assign inputSel   = inSel_ff;
  assign activeMode = active_ff;

endmodule

// ### verif/cfg_guard_assertions.sv
/* Port checker of the mode-gated write guard.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
`include "cfg_guard_defines.vh"
module cfg_guard_assertions
(
  // Clock and reset
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        clkEn,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  // Outputs
  input wire [11:0] clkOut,
  input wire        ssEnable,
  input wire [1:0]  inputSel,
  input wire        activeMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reg [7:0] wOfs_ff;
  // Offset of a taken write, held through its data phase
  always @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      wOfs_ff <= 8'hFF;
    else if (clkEn)
      wOfs_ff <= (hsel && htrans == `CG_TRANS_NONSEQ && hready && hwrite) ? haddr[7:0] : 8'hFF;
  property p_zeroWait; hreadyout; endproperty
  a_zeroWait: assert property (p_zeroWait) else $error("hreadyout low");
  property p_okay; hresp == `CG_RESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_onlyActive; !activeMode && !$past(activeMode) |-> clkOut == 12'h000; endproperty
  a_onlyActive: assert property (p_onlyActive) else $error("clock out of Active");
  property p_stop; $fell(activeMode) |=> clkOut == 12'h000; endproperty
  a_stop: assert property (p_stop) else $error("outputs not stopped");
  // Restart begins from parked outputs; the first toggle depends on the ratio
  property p_restart; $rose(activeMode) |-> clkOut == 12'h000 && $past(clkOut) == 12'h000; endproperty
  a_restart: assert property (p_restart) else $error("divider not restarted");
  property p_modeWr; wOfs_ff == `CG_MODE_OFS && clkEn |=> activeMode == !$past(hwdata[0]); endproperty
  a_modeWr: assert property (p_modeWr) else $error("mode write lost");
  property p_ssWr; wOfs_ff == `CG_SS_OFS && clkEn |=> ssEnable == $past(hwdata[0]); endproperty
  a_ssWr: assert property (p_ssWr) else $error("spread write lost");
  property p_selWr; wOfs_ff == `CG_INSEL_OFS && clkEn |=> inputSel == $past(hwdata[1:0]); endproperty
  a_selWr: assert property (p_selWr) else $error("select write lost");
  c_ready: cover property ($fell(activeMode));
  c_active: cover property ($rose(activeMode));
  c_clk: cover property (clkOut[0]);
endmodule
bind mode_gated_config_write_guard cfg_guard_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .clkOut(clkOut), .ssEnable(ssEnable),
  .inputSel(inputSel), .activeMode(activeMode));

// ### verif/ahb_host.sv
/* Host model: single-word AHB-Lite transfers.
   Assumes one slave whose hreadyout is the bus's hready. */
`timescale 1ns/1ps
module ahb_host
(
  // Clock
  input wire        sys_clk,
  // Bus
  output reg        hsel = 1'b0,
  output reg [31:0] haddr = 32'h0000_0000,
  output reg [1:0]  htrans = 2'h0,
  output reg        hwrite = 1'b0,
  output reg [2:0]  hsize = 3'h2,
  output reg [31:0] hwdata = 32'h0000_0000,
  input wire        hready,
  input wire [31:0] hrdata,
  // Bound ran out
  output reg        hung = 1'b0
);
  // Wait for hready high at a rising edge
  task waitRdy;
    integer n;
    begin
      n = 0;
      @(posedge sys_clk);
      while (hready !== 1'b1 && n < 64)
      begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (hready !== 1'b1)
        hung <= 1'b1;
    end
  endtask
  // Only bus access of the host, no stray cycles
  task xfer(input w, input [7:0] ofs, input [31:0] d, output [31:0] q);
    begin
      hsel <= 1'b1;
      haddr <= {24'h00_0000, ofs};
      hwrite <= w;
      htrans <= 2'h2;
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
      q = hrdata;
      hwdata <= ~d; // Released data shows no stale value
    end
  endtask
endmodule

// ### verif/mode_gated_config_write_guard_tb_top.sv
/* Bench of the write guard: register traffic through the host model.
   Assumes a 250 MHz sys_clk and the offsets of the defines header. */
`timescale 1ns/1ps
`include "cfg_guard_defines.vh"
module mode_gated_config_write_guard_tb_top;
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         clkEn = 1'b1;
  wire        hsel, hwrite, hready, hresp, ssEnable, activeMode, hung;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0]  htrans, inputSel;
  wire [2:0]  hsize;
  wire [11:0] clkOut;
  reg [31:0]  q;
  reg [11:0]  held;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     n;
  // Clock
  always #2 sys_clk = ~sys_clk;
  ahb_host u_host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hung(hung));
  mode_gated_config_write_guard u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .clkOut(clkOut), .ssEnable(ssEnable),
    .inputSel(inputSel), .activeMode(activeMode));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task rdChk(input string nm, input [7:0] a, input [31:0] e);
    begin
      u_host.xfer(1'b0, a, 32'h0000_0000, q);
      chk(nm, e, q);
    end
  endtask
  // Cycles clkOut[0] stays high, from its first rise after a low level on
  task halfPer;
    begin
      n = 0;
      while (clkOut[0] !== 1'b0 && n < 99)
      begin
        @(negedge sys_clk);
        n = n + 1;
      end
      while (clkOut[0] !== 1'b1 && n < 99)
      begin
        @(negedge sys_clk);
        n = n + 1;
      end
      // A clock that never rises is a mismatch
      if (clkOut[0] !== 1'b1)
        fails = fails + 1;
      n = 0;
      while (clkOut[0] === 1'b1 && n < 99)
      begin
        @(negedge sys_clk);
        n = n + 1;
      end
      // A clock stuck high is a mismatch
      if (n >= 99)
        fails = fails + 1;
      @(posedge sys_clk);
    end
  endtask
  // Hung bus ends the run
  always @(posedge sys_clk)
    if (hung === 1'b1)
    begin
      fails = fails + 1;
      stop_test;
    end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rdChk("status", `CG_STATUS_OFS, 32'h0000_0001);
    wr(`CG_OE_OFS, 32'h0000_0001);
    wr(`CG_CFG0_OFS, 32'h0000_0003);
    rdChk("cfg0", `CG_CFG0_OFS, 32'h0000_0000);
    halfPer;
    chk("half0", 32'h0000_0001, n);
    wr(`CG_SS_OFS, 32'h0000_0001);
    wr(`CG_INSEL_OFS, 32'h0000_0003);
    wr(`CG_MODE_OFS, 32'h0000_0001);
    rdChk("status", `CG_STATUS_OFS, 32'h0000_0002);
    chk("active", 32'h0000_0000, {31'h0, activeMode});
    chk("ss", 32'h0000_0001, {31'h0, ssEnable});
    chk("insel", 32'h0000_0003, {30'h0, inputSel});
    wr(`CG_SS_OFS, 32'h0000_0000);
    wr(`CG_CFG0_OFS, 32'h0000_0003);
    rdChk("cfg0", `CG_CFG0_OFS, 32'h0000_0003);
    chk("ssReady", 32'h0000_0000, {31'h0, ssEnable});
    wr(8'h40, 32'hFFFF_FFFF);
    rdChk("unmapped", 8'h40, 32'h0000_0000);
    chk("clkStop", 32'h0000_0000, {20'h0, clkOut});
    wr(`CG_MODE_OFS, 32'h0000_0000);
    rdChk("status", `CG_STATUS_OFS, 32'h0000_0001);
    chk("active", 32'h0000_0001, {31'h0, activeMode});
    halfPer;
    chk("half3", 32'h0000_0004, n);
    wr(`CG_CFG1_OFS, 32'h0000_0005);
    rdChk("cfg1", `CG_CFG1_OFS, 32'h0000_0000);
    // Enable low freezes the running divider; half a period later it must not have moved
    clkEn <= 1'b0;
    @(posedge sys_clk);
    held = clkOut;
    repeat (4) @(posedge sys_clk);
    chk("frozen", {20'h0, held}, {20'h0, clkOut});
    clkEn <= 1'b1;
    @(posedge sys_clk);
    // Reset in mid-run brings back Active mode and reset values
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("selReset", 32'h0000_0000, {30'h0, inputSel});
    rdChk("status", `CG_STATUS_OFS, 32'h0000_0001);
    rdChk("cfg0", `CG_CFG0_OFS, 32'h0000_0000);
    stop_test;
  end
endmodule
